/* File: core/io_line_pkg.sv */
// Notes on behaviour
// R1 - a line selector picks the single output line that all settings target
// R2 - invert setting true flips the output line, false passes it unchanged
// R3 - source off keeps the output line disabled, no source driven
// R4 - exposure-window source drives a pulse as long as each exposure
// R5 - exposure-window signal rises at exposure start, falls at exposure end
// R6 - readout-window source drives a pulse covering each frame readout
// R7 - software-level source drives the line low or high from one bit
// R8 - timer-pulse source drives the line from the pulse timer output
// R9 - filter accepts a level only after it held the programmed time
// R10 - highs and lows shorter than the filter time leave the output alone
// R11 - an accepted input change shows one filter time after it arrived
// R12 - exactly one pulse timer, triggered only by the exposure window
// R13 - pulse length programmable from 0 to 60,000,000 us
// R14 - pulse delay programmable from 0 to 60,000,000 us after trigger
// R15 - restart command clears the timer state; it runs again only on the next trigger
// R16 - trigger origin off never triggers; exposure makes exposure the trigger
// R17 - edge condition triggers on the chosen rising or falling edge
// R18 - level condition output valid only while trigger holds chosen level
// R19 - level high: count delay, then output high while source stays high
// R20 - edge condition: after delay, output high for exactly the length
// R21 - inversion is applied after source selection
package io_line_pkg;

	//--------------------------------------------------------------
	// timing
	//--------------------------------------------------------------
	localparam int CLK_MHZ          = 250;
	localparam int US_W             = 26;
	localparam int FILTER_US_MAX    = 1000000;
	localparam int TIMER_US_MAX     = 60000000;
	// default filter time is 0.5 us, kept in ns
	localparam int FILTER_NS_DFLT   = 500;
	localparam int FILTER_CYC_DFLT  = (FILTER_NS_DFLT * CLK_MHZ) / 1000;

	//--------------------------------------------------------------
	// register map (word offsets on the plain port)
	//--------------------------------------------------------------
	localparam logic [3:0] OFS_LINE_CTRL   = 4'h0;
	localparam logic [3:0] OFS_FILTER_TIME = 4'h1;
	localparam logic [3:0] OFS_PULSE_LEN   = 4'h2;
	localparam logic [3:0] OFS_PULSE_DLY   = 4'h3;
	localparam logic [3:0] OFS_TIMER_CTRL  = 4'h4;
	localparam logic [3:0] OFS_STATUS      = 4'h5;

	// line control fields
	localparam int LC_SEL_LSB = 0;
	localparam int LC_INV_BIT = 4;
	localparam int LC_SW_BIT  = 5;
	localparam int LC_LINE_BIT = 8;
	// timer control fields
	localparam int TC_ORG_BIT  = 0;
	localparam int TC_COND_LSB = 4;
	localparam int TC_RST_BIT  = 8;

	typedef enum logic [2:0] {
		SRC_OFF      = 3'h0,
		SRC_EXPOSURE = 3'h1,
		SRC_READOUT  = 3'h2,
		SRC_SOFTWARE = 3'h3,
		SRC_TIMER    = 3'h4
	} line_src_t;

	typedef enum logic [1:0] {
		COND_FALL = 2'h0,
		COND_RISE = 2'h1,
		COND_LOW  = 2'h2,
		COND_HIGH = 2'h3
	} trig_cond_t;

	localparam line_src_t  SRC_RESET  = SRC_OFF;
	localparam trig_cond_t COND_RESET = COND_RISE;

endpackage : io_line_pkg

/* File: core/pulse_cfg_if.sv */
`timescale 1ns/1ps
interface pulse_cfg_if;
	import io_line_pkg::*;
	logic              enable;
	trig_cond_t        cond;
	logic [US_W-1:0]   delay_us;
	logic [US_W-1:0]   length_us;
	logic              restart;
	logic              us_tick;
	logic              pulse;
	logic              busy;
	modport ctrl (output enable, cond, delay_us, length_us, restart, us_tick,
		input pulse, busy);
	modport timer (input enable, cond, delay_us, length_us, restart, us_tick,
		output pulse, busy);
endinterface : pulse_cfg_if

/* File: core/pulse_timer.sv */
`timescale 1ns/1ps
module pulse_timer
	import io_line_pkg::*;
(
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_b,
	// trigger signal, exposure window
	input  wire logic  trig_sig,
	// configuration and result
	pulse_cfg_if.timer cfg
);
	import io_line_pkg::*;

	typedef enum logic [1:0] {IDLE, WAIT_DLY, ACTIVE} tstate_t;

	tstate_t         state_reg;
	logic [US_W-1:0] cnt_reg;
	logic            trig_d_reg;
	logic            edge_hit;
	logic            level_ok;

	// level conditions treat the window level, edges one sample of change
	always_comb begin
		unique case (cfg.cond)
			COND_FALL: edge_hit = trig_d_reg & ~trig_sig; // R17
			COND_RISE: edge_hit = ~trig_d_reg & trig_sig; // R17
			COND_LOW:  edge_hit = trig_d_reg & ~trig_sig;
			COND_HIGH: edge_hit = ~trig_d_reg & trig_sig; // R19
		endcase
		level_ok = (cfg.cond == COND_HIGH) ? trig_sig : ~trig_sig; // R18
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			trig_d_reg <= 1'b0;
		else
			trig_d_reg <= trig_sig;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= IDLE;
			cnt_reg   <= '0;
		end else if (cfg.restart) begin
			// clears state; timer then waits for the next trigger
			state_reg <= IDLE; // R15
			cnt_reg   <= '0;
		end else begin
			unique case (state_reg)
				IDLE: begin
					if (cfg.enable && edge_hit) begin // R12 R16
						state_reg <= WAIT_DLY;
						cnt_reg   <= '0;
					end
				end
				WAIT_DLY: begin
					if (cnt_reg >= cfg.delay_us) begin // R14
						state_reg <= ACTIVE;
						cnt_reg   <= '0;
					end else if (cfg.us_tick)
						cnt_reg <= cnt_reg + 1'b1;
				end
				ACTIVE: begin
					if (cfg.cond == COND_HIGH || cfg.cond == COND_LOW) begin
						if (!level_ok)
							state_reg <= IDLE; // R19
					end else if (cnt_reg >= cfg.length_us)
						state_reg <= IDLE; // R20 R13
					else if (cfg.us_tick)
						cnt_reg <= cnt_reg + 1'b1;
				end
				default: state_reg <= IDLE;
			endcase
		end
	end

	assign cfg.busy = (state_reg != IDLE);
	// zero length in edge mode yields no pulse
	assign cfg.pulse = (state_reg == ACTIVE) &&
		(((cfg.cond == COND_HIGH) || (cfg.cond == COND_LOW)) ? level_ok
		: (cnt_reg < cfg.length_us)); // R18 R20

endmodule : pulse_timer

/* File: core/glitch_filter.sv */
`timescale 1ns/1ps
module glitch_filter
	import io_line_pkg::*;
#(
	parameter int CW = 28
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_b,
	// settings
	input  wire logic [CW-1:0] hold_cyc,
	// data
	input  wire logic          din,
	output logic               dout
);
	logic [CW-1:0] cnt_reg;
	logic          out_reg;

	// any change back to the accepted level restarts the count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			out_reg <= 1'b0;
		end else if (din == out_reg) begin
			cnt_reg <= '0; // R10
		end else if (cnt_reg + 1'b1 >= hold_cyc) begin
			out_reg <= din; // R9 R11
			cnt_reg <= '0;
		end else
			cnt_reg <= cnt_reg + 1'b1;
	end

	assign dout = out_reg;

endmodule : glitch_filter

/* File: core/io_line_ctrl.sv */
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module io_line_ctrl
	import io_line_pkg::*;
#(
	parameter int FCW = 28
) (
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST_B,
	// register port
	input  wire logic [3:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	// camera internals
	input  wire logic        EXPOSURE_WINDOW,
	input  wire logic        READOUT_WINDOW,
	// pins
	input  wire logic        TRIG_IN,
	output logic             TRIG_FILTERED,
	output logic             LINE_OUT,
	output logic             LINE_OE_B
);
	import io_line_pkg::*;

	//--------------------------------------------------------------
	// registers
	//--------------------------------------------------------------
	line_src_t       src_reg;
	logic            inv_reg;
	logic            sw_reg;
	logic            line_sel_reg;
	logic [FCW-1:0]  filt_reg;
	logic [US_W-1:0] len_reg;
	logic [US_W-1:0] dly_reg;
	logic            org_reg;
	trig_cond_t      cond_reg;
	logic            restart_reg;
	logic            out_reg;
	logic            oe_b_reg;
	logic            filt_out_reg;
	logic [31:0]     rdata_reg;
	logic [7:0]      div_reg;
	logic            tick_reg;
	logic            pin_s1_reg;
	logic            pin_s2_reg;
	logic            sel_sig;
	logic            filt_dout;

	pulse_cfg_if pcfg ();

	//--------------------------------------------------------------
	// microsecond tick
	//--------------------------------------------------------------
	// phase restarts at each trigger, so delay and length are whole us
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_reg  <= '0;
			tick_reg <= 1'b0;
		end else if (!pcfg.busy) begin
			div_reg  <= '0; // R14 R20
			tick_reg <= 1'b0;
		end else if (div_reg == 8'(CLK_MHZ - 1)) begin
			div_reg  <= '0;
			tick_reg <= 1'b1;
		end else begin
			div_reg  <= div_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// register writes
	//--------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			src_reg      <= SRC_RESET;
			inv_reg      <= 1'b0;
			sw_reg       <= 1'b0;
			line_sel_reg <= 1'b0;
			filt_reg     <= FCW'(FILTER_CYC_DFLT);
			len_reg      <= '0;
			dly_reg      <= '0;
			org_reg      <= 1'b0;
			cond_reg     <= COND_RESET;
		end else if (WR) begin
			unique case (ADDR)
				OFS_LINE_CTRL: begin
					src_reg      <= line_src_t'(WDATA[LC_SEL_LSB +: 3]);
					inv_reg      <= WDATA[LC_INV_BIT];
					sw_reg       <= WDATA[LC_SW_BIT];
					line_sel_reg <= WDATA[LC_LINE_BIT]; // R1
				end
				OFS_FILTER_TIME: filt_reg <= WDATA[FCW-1:0]; // R9
				OFS_PULSE_LEN:   len_reg  <= WDATA[US_W-1:0]; // R13
				OFS_PULSE_DLY:   dly_reg  <= WDATA[US_W-1:0]; // R14
				OFS_TIMER_CTRL: begin
					org_reg  <= WDATA[TC_ORG_BIT]; // R16
					cond_reg <= trig_cond_t'(WDATA[TC_COND_LSB +: 2]);
				end
				default: ;
			endcase
		end
	end

	// restart is a self-clearing command bit
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B)
			restart_reg <= 1'b0;
		else
			restart_reg <= WR && (ADDR == OFS_TIMER_CTRL) &&
				WDATA[TC_RST_BIT]; // R15
	end

	//--------------------------------------------------------------
	// register reads, one cycle later; unmapped reads zero
	//--------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B)
			rdata_reg <= '0;
		else if (RD) begin
			unique case (ADDR)
				OFS_LINE_CTRL: rdata_reg <= 32'({line_sel_reg, 2'h0, sw_reg,
					inv_reg, 1'b0, src_reg});
				OFS_FILTER_TIME: rdata_reg <= 32'(filt_reg);
				OFS_PULSE_LEN:   rdata_reg <= 32'(len_reg);
				OFS_PULSE_DLY:   rdata_reg <= 32'(dly_reg);
				OFS_TIMER_CTRL:  rdata_reg <= 32'({cond_reg, 3'h0, org_reg});
				OFS_STATUS:      rdata_reg <= 32'({pcfg.busy, pcfg.pulse,
					filt_out_reg, out_reg});
				default:         rdata_reg <= '0;
			endcase
		end else
			rdata_reg <= '0;
	end

	//--------------------------------------------------------------
	// input pin: sync then filter
	//--------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
		end else begin
			pin_s1_reg <= TRIG_IN;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	glitch_filter #(.CW(FCW)) u_filter (
		.clk      (SYS_CLK),
		.rst_b    (RST_B),
		.hold_cyc (filt_reg),
		.din      (pin_s2_reg),
		.dout     (filt_dout)
	);

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B)
			filt_out_reg <= 1'b0;
		else
			filt_out_reg <= filt_dout; // R11
	end

	//--------------------------------------------------------------
	// pulse timer
	//--------------------------------------------------------------
	assign pcfg.enable    = org_reg; // R16
	assign pcfg.cond      = cond_reg;
	assign pcfg.delay_us  = dly_reg;
	assign pcfg.length_us = len_reg;
	assign pcfg.restart   = restart_reg;
	assign pcfg.us_tick   = tick_reg;

	// exposure window is the only trigger signal offered
	pulse_timer u_timer (
		.clk      (SYS_CLK),
		.rst_b    (RST_B),
		.trig_sig (EXPOSURE_WINDOW), // R12
		.cfg      (pcfg)
	);

	//--------------------------------------------------------------
	// output line
	//--------------------------------------------------------------
	always_comb begin
		unique case (src_reg)
			SRC_EXPOSURE: sel_sig = EXPOSURE_WINDOW; // R4 R5
			SRC_READOUT:  sel_sig = READOUT_WINDOW; // R6
			SRC_SOFTWARE: sel_sig = sw_reg; // R7
			SRC_TIMER:    sel_sig = pcfg.pulse; // R8
			default:      sel_sig = 1'b0; // R3
		endcase
	end

	// only line 0 exists; selecting another leaves the pin undriven
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			out_reg  <= 1'b0;
			oe_b_reg <= 1'b1;
		end else begin
			out_reg  <= sel_sig ^ inv_reg; // R2 R21
			oe_b_reg <= (src_reg == SRC_OFF) || line_sel_reg; // R3 R1
		end
	end

	assign RDATA         = rdata_reg;
	assign LINE_OUT      = out_reg;
	assign LINE_OE_B     = oe_b_reg;
	assign TRIG_FILTERED = filt_out_reg;

endmodule : io_line_ctrl

/* File: test/io_line_ctrl_assertions.sv */
`timescale 1ns/1ps
module io_line_ctrl_assertions #(
	parameter int FCW = 28
) (
	// clock and reset
	input wire logic        SYS_CLK,
	input wire logic        RST_B,
	// register port
	input wire logic [3:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [31:0] RDATA,
	// camera internals and pins
	input wire logic        EXPOSURE_WINDOW,
	input wire logic        READOUT_WINDOW,
	input wire logic        TRIG_IN,
	input wire logic        TRIG_FILTERED,
	input wire logic        LINE_OUT,
	input wire logic        LINE_OE_B
);
	import io_line_pkg::*;
	// shadow of line control, so outputs can be tied to settings
	logic [8:0] ctl_reg;
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B)
			ctl_reg <= 9'h0;
		else if (WR && ADDR == OFS_LINE_CTRL)
			ctl_reg <= WDATA[8:0];
	end
	wire logic [2:0] src = ctl_reg[2:0];
	wire logic       inv = ctl_reg[LC_INV_BIT];
	wire logic       on0 = !ctl_reg[LC_LINE_BIT];
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_B);
	//------------------------------------------------------------
	// line output
	//------------------------------------------------------------
	property p_off;
		src == SRC_OFF |=> LINE_OE_B;
	endproperty
	a_off: assert property (p_off)
		else $error("line driven while source off");
	property p_sel;
		!on0 |=> LINE_OE_B;
	endproperty
	a_sel: assert property (p_sel)
		else $error("line driven while other line selected");
	property p_sw;
		src == SRC_SOFTWARE && on0
		|=> !LINE_OE_B && LINE_OUT == $past(ctl_reg[LC_SW_BIT] ^ inv);
	endproperty
	a_sw: assert property (p_sw)
		else $error("software level wrong");
	property p_exp;
		src == SRC_EXPOSURE && on0
		|=> LINE_OUT == $past(EXPOSURE_WINDOW ^ inv);
	endproperty
	a_exp: assert property (p_exp)
		else $error("exposure window not followed");
	property p_rdo;
		src == SRC_READOUT && on0
		|=> LINE_OUT == $past(READOUT_WINDOW ^ inv);
	endproperty
	a_rdo: assert property (p_rdo)
		else $error("readout window not followed");
	property p_tmr;
		(src == SRC_TIMER && on0) [*2] |-> !LINE_OE_B;
	endproperty
	a_tmr: assert property (p_tmr)
		else $error("timer source not driving line");
	//------------------------------------------------------------
	// register port
	//------------------------------------------------------------
	property p_idle;
		!RD |=> RDATA == 32'h0;
	endproperty
	a_idle: assert property (p_idle)
		else $error("read data outside read cycle");
	property p_unmap;
		RD && ADDR > OFS_STATUS |=> RDATA == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	property p_stat;
		RD && ADDR == OFS_STATUS
		|=> RDATA[1:0] == $past({TRIG_FILTERED, LINE_OUT});
	endproperty
	a_stat: assert property (p_stat)
		else $error("status bits disagree with pins");
	c_exp: cover property (src == SRC_EXPOSURE ##1 $rose(LINE_OUT));
	c_filt: cover property ($rose(TRIG_FILTERED));
	c_stat: cover property (RD && ADDR == OFS_STATUS);
endmodule : io_line_ctrl_assertions

bind io_line_ctrl io_line_ctrl_assertions #(.FCW(FCW)) i_chk (
	.SYS_CLK(SYS_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .EXPOSURE_WINDOW(EXPOSURE_WINDOW),
	.READOUT_WINDOW(READOUT_WINDOW), .TRIG_IN(TRIG_IN),
	.TRIG_FILTERED(TRIG_FILTERED), .LINE_OUT(LINE_OUT),
	.LINE_OE_B(LINE_OE_B)
);

/* File: test/strobe_equipment.sv */
`timescale 1ns/1ps
module strobe_equipment (
	// clock
	input  wire logic clk,
	// strobe pin from the camera
	input  wire logic line_out,
	input  wire logic line_oe_b,
	// width of the last completed flash, in cycles
	output int        hi_len
);
	// released pin falls to the input's pull-down
	wire logic pin = !line_oe_b && line_out;
	int run_reg = 0;
	always @(posedge clk) begin
		run_reg <= pin ? run_reg + 1 : 0;
		if (!pin && run_reg > 0)
			hi_len <= run_reg;
	end
endmodule : strobe_equipment

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import io_line_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0, rd = 1'b0, trig = 1'b0;
	logic        expo = 1'b0, rdo = 1'b0;
	logic [31:0] rdata;
	logic        filt, line, oe_b;
	logic [31:0] seed = 32'h8;
	int          n_mismatch = 0, samples_checked = 0, cyc = 0, hi_len;
	// rise, fall, level high, origin off, restart, level low
	int tcs[6] = '{32'h11, 32'h01, 32'h31, 32'h10, 32'h11, 32'h21};
	int his[6] = '{300, 300, 1200, 300, 300, 300};
	int rss[6] = '{-1, -1, -1, -1, 200, -1};
	io_line_ctrl #(.FCW(28)) i_io_line_ctrl (
		.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .EXPOSURE_WINDOW(expo),
		.READOUT_WINDOW(rdo), .TRIG_IN(trig), .TRIG_FILTERED(filt),
		.LINE_OUT(line), .LINE_OE_B(oe_b));
	strobe_equipment i_strobe_equipment (.clk(sys_clk), .line_out(line),
		.line_oe_b(oe_b), .hi_len(hi_len));
	initial forever #2 sys_clk = ~sys_clk;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic want(logic [2:0] s, logic i, logic sw,
		logic e, logic r);
		if (s == SRC_EXPOSURE)
			return e ^ i;
		if (s == SRC_READOUT)
			return r ^ i;
		return sw ^ i;
	endfunction : want
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	// gap cycle after each strobe keeps one assignment per time step
	task automatic wreg(logic [3:0] a, logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wreg
	task automatic rreg(string nm, logic [3:0] a, logic [31:0] m,
		logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		chk(nm, rdata & m, e);
		@(posedge sys_clk);
	endtask : rreg
	// one exposure with timer control written at start, restart at rs
	task automatic shot(logic [31:0] tc, int hi, int rs, output int rise);
		rise = -1;
		for (int j = 0; j < 2600; j++) begin
			addr <= OFS_TIMER_CTRL;
			wdata <= j == rs ? tc | 32'h100 : tc;
			wr <= j == 0 || j == rs;
			expo <= j >= 100 && j < 100 + hi;
			@(posedge sys_clk);
			#1;
			if (line && rise < 0)
				rise = j;
		end
	endtask : shot
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		logic [31:0] v;
		logic [2:0]  s;
		logic [8:0]  c;
		int          lat;
		int          r;
		int          tt;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		rreg("filter_dflt", OFS_FILTER_TIME, '1, FILTER_CYC_DFLT);
		rreg("unmapped", 4'hf, '1, 32'h0);
		$display("register test done");
		for (int k = 0; k < 32; k++) begin
			v = xs();
			s = 3'(k % 4);
			c = {k % 8 == 7, 2'h0, v[5:4], 1'b0, s};
			wreg(OFS_LINE_CTRL, {23'h0, c});
			for (int j = 0; j < 12; j++) begin
				v = xs();
				expo <= v[0];
				rdo <= v[1];
				trig <= v[2];
				@(posedge sys_clk);
				#1;
				chk("oe_b", oe_b, s == SRC_OFF || c[8]);
				if (s != SRC_OFF && !c[8])
					chk("line", line, want(s, c[4], c[5], v[0], v[1]));
			end
		end
		wreg(OFS_LINE_CTRL, 32'h23);
		rreg("status", OFS_STATUS, 32'h1, 32'h1);
		$display("source test done");
		wreg(OFS_FILTER_TIME, 32'h6);
		trig <= 1'b0;
		repeat (20) @(posedge sys_clk);
		for (int w = 4; w < 9; w++) begin
			lat = -1;
			for (int j = 0; j < 30; j++) begin
				trig <= j < w;
				@(posedge sys_clk);
				#1;
				if (filt && lat < 0)
					lat = j;
			end
			chk("filt_pass", lat >= 0, w >= 6);
			if (lat >= 0)
				chk("filt_delay", lat >= 6 && lat <= 10, 1'b1);
		end
		$display("filter test done");
		wreg(OFS_PULSE_DLY, 32'h2);
		wreg(OFS_PULSE_LEN, 32'h3);
		wreg(OFS_LINE_CTRL, 32'h4);
		for (int k = 0; k < 6; k++) begin
			shot(tcs[k], his[k], rss[k], r);
			tt = tcs[k][4] ? 100 : 100 + his[k];
			if (!tcs[k][0] || rss[k] > 0)
				chk("no_pulse", r, -1);
			else begin
				chk("delay", r >= tt + 249 && r <= tt + 506, 1'b1);
				if (k == 2)
					chk("lvl_end", r + hi_len >= 1298 && r + hi_len <= 1305, 1'b1);
				else if (k < 2)
					chk("length", hi_len >= 748 && hi_len <= 752, 1'b1);
				else begin
					chk("held", line, 1'b1);
					rreg("tmr_stat", OFS_STATUS, 32'hd, 32'hd);
				end
			end
			$display("timer case %0d done", k);
		end
		tally_and_finish();
	end
endmodule : testbench
